// *** src/xbw_map.svh ***
// Register offsets, field positions, reset values and timing counts of the wait-state block
`ifndef XBW_MAP_SVH
`define XBW_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses on the register bus)
// ----------------------------------------------------------------
`define XBW_CFG_OFS 8'h00
`define XBW_STATUS_OFS 8'h04

// ----------------------------------------------------------------
// Wait-state configuration fields
// ----------------------------------------------------------------
`define XBW_LOW_PROG_LSB 0
`define XBW_HIGH_PROG_LSB 3
`define XBW_DATA_LSB 6
`define XBW_IO_LSB 9
`define XBW_CFG_BITS 12
`define XBW_CFG_RESET 12'hfff

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define XBW_ST_BUSY_BIT 0
`define XBW_ST_READY_BIT 1
`define XBW_ST_MODE_BIT 2
`define XBW_ST_ROM_BIT 3
`define XBW_ST_SPACE_LSB 4
`define XBW_ST_CNT_LSB 8

// ----------------------------------------------------------------
// Address map and timing
// ----------------------------------------------------------------
`define XBW_PROG_HALF_BIT 15
`define XBW_CFG_IO_ADDR 16'hffff
`define XBW_ROM_TOP 16'h3fff
`define XBW_CYCLE_DIV 2

`endif

// *** src/xbw_pkg.sv ***
// Types shared by the external bus wait-state block
package xbw_pkg;

    typedef enum logic [1:0] {
        XBW_SPACE_PROG,
        XBW_SPACE_DATA,
        XBW_SPACE_IO,
        XBW_SPACE_NONE
    } xbw_space_e;

    typedef enum logic [1:0] {
        XBW_IDLE,
        XBW_ACCESS,
        XBW_TURN
    } xbw_state_e;

endpackage

// *** src/xbw_cycle_div.sv ***
// CPU cycle divider: one-cycle enable pulse and the cycle clock driven out
`timescale 1ns/10ps
`include "xbw_map.svh"
module xbw_cycle_div #(
    parameter int DIV = `XBW_CYCLE_DIV
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Cycle timing
    output logic cyc_en_o,
    output logic cyc_clk_o
);
    logic [7:0] cnt_q, cnt_d;
    logic en_q, en_d;
    logic clk_q, clk_d;

    always_comb begin
        cnt_d = (cnt_q == 8'(DIV - 1)) ? 8'h00 : cnt_q + 8'h01;
        en_d = (cnt_q == 8'(DIV - 1));
        // High for the first half of each CPU cycle
        clk_d = (cnt_d < 8'(DIV / 2)) || (DIV == 1);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 8'h00;
            en_q <= 1'b0;
            clk_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            en_q <= en_d;
            clk_q <= clk_d;
        end
    end

    assign cyc_en_o = en_q;
    assign cyc_clk_o = clk_q;
endmodule

// *** src/xbw_regs.sv ***
// Wishbone register slave holding the wait-state configuration and showing status
`timescale 1ns/10ps
`include "xbw_map.svh"
module xbw_regs (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Configuration write from the I/O space side
    input wire logic io_we_i,
    input wire logic [15:0] io_wdata_i,
    // Block state
    input wire logic [15:0] status_i,
    output logic [`XBW_CFG_BITS-1:0] cfg_o
);
    logic [`XBW_CFG_BITS-1:0] cfg_q, cfg_d;
    logic [31:0] dat_q, dat_d;
    logic ack_q, ack_d;
    logic req;

    function automatic logic [15:0] merge_bytes(input logic [15:0] old_v, input logic [31:0] new_v,
                                                input logic [3:0] sel);
        logic [15:0] r;
        r = old_v;
        if (sel[0]) begin
            r[7:0] = new_v[7:0];
        end
        if (sel[1]) begin
            r[15:8] = new_v[15:8];
        end
        return r;
    endfunction

    always_comb begin
        logic [15:0] wide;
        wide = 16'h0000;
        req = wb_cyc_i && wb_stb_i && !ack_q;
        cfg_d = cfg_q;
        dat_d = 32'h0000_0000;
        ack_d = req;
        // The register bus wins when both sides write in one cycle
        if (io_we_i) begin
            cfg_d = io_wdata_i[`XBW_CFG_BITS-1:0];
        end
        if (req && wb_we_i && wb_adr_i == `XBW_CFG_OFS) begin
            wide = merge_bytes({4'h0, cfg_q}, wb_dat_i, wb_sel_i);
            cfg_d = wide[`XBW_CFG_BITS-1:0];
        end
        if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                `XBW_CFG_OFS: dat_d = {20'h00000, cfg_q};
                `XBW_STATUS_OFS: dat_d = {16'h0000, status_i};
                default: dat_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_q <= `XBW_CFG_RESET;
            dat_q <= 32'h0000_0000;
            ack_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            dat_q <= dat_d;
            ack_q <= ack_d;
        end
    end

    assign wb_dat_o = dat_q;
    assign wb_ack_o = ack_q;
    assign cfg_o = cfg_q;
endmodule

// *** src/xbw_top.sv ***
// External memory interface with programmable and ready-driven wait states
//
// The Wishbone interface to the registers and the register addresses were decided locally.
`timescale 1ns/10ps
`include "xbw_map.svh"
module xbw_top
    import xbw_pkg::*;
#(
    parameter int CYCLE_DIV = `XBW_CYCLE_DIV,
    parameter logic [15:0] ROM_TOP = `XBW_ROM_TOP,
    parameter logic [15:0] CFG_IO_ADDR = `XBW_CFG_IO_ADDR
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone register slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // CPU access request
    input wire logic cpu_req_i,
    input wire logic [1:0] cpu_space_i,
    input wire logic cpu_we_i,
    input wire logic [15:0] cpu_addr_i,
    input wire logic [15:0] cpu_wdata_i,
    output logic cpu_done_o,
    output logic [15:0] cpu_rdata_o,
    output logic rom_hit_o,
    // External bus pins
    output logic [15:0] ext_addr_o,
    output logic [15:0] ext_data_o,
    output logic ext_data_oe_o,
    input wire logic [15:0] ext_data_i,
    output logic read_n_o,
    output logic write_enable_n_o,
    output logic external_access_strobe_n_o,
    output logic program_select_n_o,
    output logic data_space_select_n_o,
    output logic io_space_select_n_o,
    output logic read_not_write_o,
    input wire logic ready_i,
    // Mode and clock
    input wire logic boot_memory_mode_select_i,
    output logic onchip_rom_enable_o,
    output logic cpu_cycle_clock_out_o
);
    // ----------------------------------------------------------------
    // CPU cycle timing
    // ----------------------------------------------------------------
    logic cyc_en;
    logic cyc_clk;

    xbw_cycle_div #(
        .DIV(CYCLE_DIV)
    ) u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cyc_en_o(cyc_en),
        .cyc_clk_o(cyc_clk)
    );

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [`XBW_CFG_BITS-1:0] cfg;
    logic [15:0] status;
    logic cfg_we_q, cfg_we_d;
    logic [15:0] cfg_wdata_q, cfg_wdata_d;

    xbw_regs u_regs (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .io_we_i(cfg_we_q),
        .io_wdata_i(cfg_wdata_q),
        .status_i(status),
        .cfg_o(cfg)
    );

    // Wait count for a space; program space splits on the top address bit
    function automatic logic [2:0] wait_for(input logic [1:0] space, input logic [15:0] addr,
                                            input logic [`XBW_CFG_BITS-1:0] c);
        logic [2:0] w;
        w = 3'h0;
        if (space == XBW_SPACE_PROG && !addr[`XBW_PROG_HALF_BIT]) begin
            w = c[`XBW_LOW_PROG_LSB +: 3];
        end else if (space == XBW_SPACE_PROG) begin
            w = c[`XBW_HIGH_PROG_LSB +: 3];
        end else if (space == XBW_SPACE_DATA) begin
            w = c[`XBW_DATA_LSB +: 3];
        end else if (space == XBW_SPACE_IO) begin
            w = c[`XBW_IO_LSB +: 3];
        end
        return w;
    endfunction

    // ----------------------------------------------------------------
    // Access sequencer
    // ----------------------------------------------------------------
    xbw_state_e state_q, state_d;
    logic [2:0] cnt_q, cnt_d;
    logic [1:0] space_q, space_d;
    logic done_q, done_d;
    logic [15:0] rdata_q, rdata_d;
    logic rom_hit_q, rom_hit_d;
    logic [15:0] addr_q, addr_d;
    logic [15:0] wdata_q, wdata_d;
    logic oe_q, oe_d;
    logic rd_n_q, rd_n_d;
    logic we_n_q, we_n_d;
    logic external_access_strobe_n_q, external_access_strobe_n_d;
    logic ps_n_q, ps_n_d;
    logic ds_n_q, ds_n_d;
    logic is_n_q, is_n_d;
    logic rnw_q, rnw_d;
    logic rom_en_q, rom_en_d;
    logic clk_out_q;
    logic cfg_hit;
    logic rom_hit;
    logic micro_mode;

    // Pin high is microprocessor mode: on-chip ROM off
    assign micro_mode = boot_memory_mode_select_i;
    assign cfg_hit = cpu_space_i == XBW_SPACE_IO && cpu_addr_i == CFG_IO_ADDR;
    assign rom_hit = cpu_space_i == XBW_SPACE_PROG && !micro_mode && cpu_addr_i <= ROM_TOP;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        space_d = space_q;
        done_d = 1'b0;
        rdata_d = rdata_q;
        rom_hit_d = 1'b0;
        addr_d = addr_q;
        wdata_d = wdata_q;
        oe_d = oe_q;
        rd_n_d = rd_n_q;
        we_n_d = we_n_q;
        external_access_strobe_n_d = external_access_strobe_n_q;
        ps_n_d = ps_n_q;
        ds_n_d = ds_n_q;
        is_n_d = is_n_q;
        rnw_d = rnw_q;
        cfg_we_d = 1'b0;
        cfg_wdata_d = cfg_wdata_q;
        rom_en_d = !micro_mode;
        unique case (state_q)
            XBW_IDLE: begin
                if (cyc_en && cpu_req_i) begin
                    if (cfg_hit) begin
                        // Configuration lives in I/O space but never leaves the chip
                        cfg_we_d = cpu_we_i;
                        cfg_wdata_d = cpu_wdata_i;
                        rdata_d = {4'h0, cfg};
                        done_d = 1'b1;
                        state_d = XBW_TURN;
                    end else if (rom_hit) begin
                        // On-chip ROM answers; writes to it are dropped
                        rom_hit_d = 1'b1;
                        done_d = 1'b1;
                        state_d = XBW_TURN;
                    end else if (cpu_space_i != XBW_SPACE_NONE) begin
                        space_d = cpu_space_i;
                        cnt_d = wait_for(cpu_space_i, cpu_addr_i, cfg);
                        addr_d = cpu_addr_i;
                        wdata_d = cpu_wdata_i;
                        oe_d = cpu_we_i;
                        rd_n_d = cpu_we_i;
                        we_n_d = !cpu_we_i;
                        external_access_strobe_n_d = 1'b0;
                        rnw_d = !cpu_we_i;
                        ps_n_d = cpu_space_i != XBW_SPACE_PROG;
                        ds_n_d = cpu_space_i != XBW_SPACE_DATA;
                        is_n_d = cpu_space_i != XBW_SPACE_IO;
                        state_d = XBW_ACCESS;
                    end else begin
                        done_d = 1'b1;
                        state_d = XBW_TURN;
                    end
                end
            end
            XBW_ACCESS: begin
                if (cyc_en) begin
                    if (cnt_q != 3'h0) begin
                        cnt_d = cnt_q - 3'h1;
                    end else if (ready_i) begin
                        rdata_d = rnw_q ? ext_data_i : rdata_q;
                        done_d = 1'b1;
                        oe_d = 1'b0;
                        rd_n_d = 1'b1;
                        we_n_d = 1'b1;
                        external_access_strobe_n_d = 1'b1;
                        ps_n_d = 1'b1;
                        ds_n_d = 1'b1;
                        is_n_d = 1'b1;
                        rnw_d = 1'b1;
                        state_d = XBW_TURN;
                    end
                end
            end
            XBW_TURN: begin
                // One idle CPU cycle lets the requester drop its request
                if (cyc_en) begin
                    state_d = XBW_IDLE;
                end
            end
            default: begin
                state_d = XBW_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= XBW_IDLE;
            cnt_q <= 3'h0;
            space_q <= XBW_SPACE_NONE;
            done_q <= 1'b0;
            rdata_q <= 16'h0000;
            rom_hit_q <= 1'b0;
            addr_q <= 16'h0000;
            wdata_q <= 16'h0000;
            oe_q <= 1'b0;
            rd_n_q <= 1'b1;
            we_n_q <= 1'b1;
            external_access_strobe_n_q <= 1'b1;
            ps_n_q <= 1'b1;
            ds_n_q <= 1'b1;
            is_n_q <= 1'b1;
            rnw_q <= 1'b1;
            cfg_we_q <= 1'b0;
            cfg_wdata_q <= 16'h0000;
            rom_en_q <= 1'b0;
            clk_out_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            space_q <= space_d;
            done_q <= done_d;
            rdata_q <= rdata_d;
            rom_hit_q <= rom_hit_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            oe_q <= oe_d;
            rd_n_q <= rd_n_d;
            we_n_q <= we_n_d;
            external_access_strobe_n_q <= external_access_strobe_n_d;
            ps_n_q <= ps_n_d;
            ds_n_q <= ds_n_d;
            is_n_q <= is_n_d;
            rnw_q <= rnw_d;
            cfg_we_q <= cfg_we_d;
            cfg_wdata_q <= cfg_wdata_d;
            rom_en_q <= rom_en_d;
            clk_out_q <= cyc_clk;
        end
    end

    // ----------------------------------------------------------------
    // Status and outputs
    // ----------------------------------------------------------------
    always_comb begin
        status = 16'h0000;
        status[`XBW_ST_BUSY_BIT] = state_q != XBW_IDLE;
        status[`XBW_ST_READY_BIT] = ready_i;
        status[`XBW_ST_MODE_BIT] = micro_mode;
        status[`XBW_ST_ROM_BIT] = rom_en_q;
        status[`XBW_ST_SPACE_LSB +: 2] = space_q;
        status[`XBW_ST_CNT_LSB +: 3] = cnt_q;
    end

    assign cpu_done_o = done_q;
    assign cpu_rdata_o = rdata_q;
    assign rom_hit_o = rom_hit_q;
    assign ext_addr_o = addr_q;
    assign ext_data_o = wdata_q;
    assign ext_data_oe_o = oe_q;
    assign read_n_o = rd_n_q;
    assign write_enable_n_o = we_n_q;
    assign external_access_strobe_n_o = external_access_strobe_n_q;
    assign program_select_n_o = ps_n_q;
    assign data_space_select_n_o = ds_n_q;
    assign io_space_select_n_o = is_n_q;
    assign read_not_write_o = rnw_q;
    assign onchip_rom_enable_o = rom_en_q;
    assign cpu_cycle_clock_out_o = clk_out_q;
endmodule

// *** test/xbw_monitor.sv ***
// Concurrent checks on the ports of the external bus wait-state block
`timescale 1ns/10ps
module xbw_monitor (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // CPU side
    input wire logic cpu_done_o,
    input wire logic rom_hit_o,
    // External pins
    input wire logic [15:0] ext_addr_o,
    input wire logic ext_data_oe_o,
    input wire logic cpu_cycle_clock_out_o,
    input wire logic read_n_o,
    input wire logic write_enable_n_o,
    input wire logic external_access_strobe_n_o,
    input wire logic program_select_n_o,
    input wire logic data_space_select_n_o,
    input wire logic io_space_select_n_o,
    input wire logic read_not_write_o,
    input wire logic ready_i,
    input wire logic boot_memory_mode_select_i,
    input wire logic onchip_rom_enable_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic [2:0] sel_n;
    logic external_access_strobe_n;
    assign sel_n = {program_select_n_o, data_space_select_n_o, io_space_select_n_o};
    assign external_access_strobe_n = external_access_strobe_n_o;
    sequence wb_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    // ----------------------------------------------------------------
    // Pin relations
    // ----------------------------------------------------------------
    one_select_a: assert property ($onehot0(~sel_n))
        else $error("more than one space select active");
    strobe_select_a: assert property (external_access_strobe_n == (&sel_n))
        else $error("strobe and space select disagree");
    read_dir_a: assert property (!read_n_o |-> read_not_write_o && !external_access_strobe_n)
        else $error("read strobe without read direction");
    write_dir_a: assert property (!write_enable_n_o |-> !read_not_write_o && !external_access_strobe_n)
        else $error("write enable without write direction");
    pins_hold_a: assert property (!external_access_strobe_n && $past(!external_access_strobe_n) |-> $stable(ext_addr_o) && $stable(read_not_write_o))
        else $error("address or direction moved during access");
    // Data pins are driven exactly while a write is on the bus
    data_oe_a: assert property (ext_data_oe_o == !write_enable_n_o)
        else $error("data output enable and write enable disagree");
    // Accesses start and end only on a rising edge of the cycle clock
    clk_align_a: assert property ($changed(external_access_strobe_n) |-> $rose(cpu_cycle_clock_out_o))
        else $error("strobe moved off the cycle clock rising edge");
    // ----------------------------------------------------------------
    // Completion and mode
    // ----------------------------------------------------------------
    strobe_done_a: assert property ($rose(external_access_strobe_n) |-> cpu_done_o)
        else $error("strobe ended without completion");
    ready_gate_a: assert property (cpu_done_o && $past(!external_access_strobe_n) |-> $past(ready_i))
        else $error("access completed while ready low");
    rom_mode_a: assert property (!$past(rst_i) |-> onchip_rom_enable_o == !$past(boot_memory_mode_select_i))
        else $error("rom enable does not follow mode pin");
    rom_quiet_a: assert property (rom_hit_o |-> external_access_strobe_n && $past(external_access_strobe_n))
        else $error("on-chip access moved external pins");
    wb_answer_a: assert property (wb_take |=> ack_pulse)
        else $error("register bus ack not a single pulse");
endmodule

// *** test/xbw_ext_mem.sv ***
// Behavioural external memory and I/O device with an optional slow ready
`timescale 1ns/10ps
module xbw_ext_mem (
    // Clock
    input wire logic clk_i,
    // Bus from the block
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic read_n_i,
    input wire logic write_enable_n_i,
    input wire logic strobe_n_i,
    input wire logic [2:0] sel_n_i,
    input wire logic [7:0] stall_i,
    // Answer
    output logic [15:0] rdata_o,
    output logic ready_o
);
    logic [15:0] mem [0:255];
    logic [15:0] last_q = 16'h0000;
    logic [7:0] cnt_q = 8'h00;
    logic [7:0] idx;
    logic rdy_q = 1'b1;
    assign idx = {sel_n_i[2:1], addr_i[15], addr_i[4:0]};
    // Released bus shows the inverse of the last word, so stale data never passes
    assign rdata_o = (!read_n_i && !strobe_n_i) ? mem[idx] : ~last_q;
    assign ready_o = rdy_q;
    always @(posedge clk_i) begin
        if (!read_n_i && !strobe_n_i) begin
            last_q <= mem[idx];
        end
        if (!write_enable_n_i && !strobe_n_i) begin
            mem[idx] <= wdata_i;
        end
        cnt_q <= strobe_n_i ? 8'h00 : cnt_q + 8'h01;
        // Ready held low for stall_i clocks, starting one clock after the strobe falls
        rdy_q <= strobe_n_i || (cnt_q >= stall_i);
    end
endmodule

// *** test/testbench.sv ***
// Self-checking bench for the external bus wait-state block
`timescale 1ns/10ps
module testbench;
    localparam int DIV = 2;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic cpu_req_i = 1'b0, cpu_we_i = 1'b0, boot_memory_mode_select_i = 1'b1;
    logic [1:0] cpu_space_i = 2'h3;
    logic [15:0] cpu_addr_i = 16'h0, cpu_wdata_i = 16'h0, cpu_rdata_o, ext_addr_o, ext_data_o, ext_data_i;
    logic cpu_done_o, rom_hit_o, ext_data_oe_o, read_n_o, write_enable_n_o, external_access_strobe_n_o;
    logic program_select_n_o, data_space_select_n_o, io_space_select_n_o, read_not_write_o, ready_i;
    logic onchip_rom_enable_o, cpu_cycle_clock_out_o;
    logic [7:0] stall = 8'h00;
    int miscompares = 0, check_count = 0;
    xbw_top #(.CYCLE_DIV(DIV)) u_xbw_top (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cpu_req_i, .cpu_space_i, .cpu_we_i, .cpu_addr_i,
        .cpu_wdata_i, .cpu_done_o, .cpu_rdata_o, .rom_hit_o, .ext_addr_o, .ext_data_o, .ext_data_oe_o,
        .ext_data_i, .read_n_o, .write_enable_n_o, .external_access_strobe_n_o, .program_select_n_o,
        .data_space_select_n_o, .io_space_select_n_o, .read_not_write_o, .ready_i,
        .boot_memory_mode_select_i, .onchip_rom_enable_o, .cpu_cycle_clock_out_o);
    xbw_ext_mem u_xbw_ext_mem (.clk_i, .addr_i(ext_addr_o), .wdata_i(ext_data_o), .read_n_i(read_n_o),
        .write_enable_n_i(write_enable_n_o), .strobe_n_i(external_access_strobe_n_o),
        .sel_n_i({program_select_n_o, data_space_select_n_o, io_space_select_n_o}),
        .stall_i(stall), .rdata_o(ext_data_i), .ready_o(ready_i));
    initial forever #2.5 clk_i = ~clk_i;
    // ----------------------------------------------------------------
    // Access tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= 4'h3;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) miscompares++;
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    // Counts clocks with the strobe active and keeps the pin pattern seen then
    task automatic cpu_acc(input logic [1:0] sp, input logic we, input logic [15:0] adr, input logic [15:0] wd,
                           output logic [15:0] rd, output int lo, output logic [5:0] pins, output logic hit);
        int n;
        @(posedge clk_i);
        cpu_req_i <= 1'b1;
        cpu_space_i <= sp;
        cpu_we_i <= we;
        cpu_addr_i <= adr;
        cpu_wdata_i <= wd;
        lo = 0;
        n = 0;
        pins = 6'h3f;
        do begin
            @(posedge clk_i);
            n++;
            if (external_access_strobe_n_o === 1'b0) begin
                lo++;
                pins = {program_select_n_o, data_space_select_n_o, io_space_select_n_o,
                        read_n_o, write_enable_n_o, read_not_write_o};
            end
        end while (cpu_done_o !== 1'b1 && n < 300);
        if (n >= 300) miscompares++;
        hit = rom_hit_o;
        rd = cpu_rdata_o;
        cpu_req_i <= 1'b0;
    endtask
    function automatic logic [2:0] sel_exp(input logic [1:0] sp);
        return (sp == 2'h0) ? 3'h3 : (sp == 2'h1) ? 3'h5 : 3'h6;
    endfunction
    task automatic ext_test(input logic [1:0] sp, input logic [15:0] adr, input int w, input logic [15:0] wd);
        logic [15:0] rd;
        int lo;
        logic [5:0] pins;
        logic hit;
        cpu_acc(sp, 1'b1, adr, wd, rd, lo, pins, hit);
        check("write clocks", lo, (w + 1) * DIV);
        check("write pins", pins, {sel_exp(sp), 3'h4});
        cpu_acc(sp, 1'b0, adr, 16'h0, rd, lo, pins, hit);
        check("read clocks", lo, (w + 1) * DIV);
        check("read pins", pins, {sel_exp(sp), 3'h3});
        check("read data", rd, wd);
    endtask
    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic [15:0] rd;
        int lo;
        logic [5:0] pins;
        logic hit;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wb_xfer(1'b0, 8'h00, 32'h0, r);
        check("cfg reset", r, 32'h0fff);
        wb_xfer(1'b0, 8'h04, 32'h0, r);
        check("status mode", r & 32'hc, 32'h4);
        wb_xfer(1'b0, 8'h08, 32'h0, r);
        check("unmapped read", r, 32'h0);
        wb_xfer(1'b1, 8'h08, 32'hffff_ffff, r);
        wb_xfer(1'b1, 8'h00, 32'h00d1, r);
        wb_xfer(1'b0, 8'h00, 32'h0, r);
        check("cfg write", r, 32'h00d1);
        ext_test(2'h0, 16'h0010, 1, 16'ha5a1);
        ext_test(2'h0, 16'h8010, 2, 16'h5a52);
        ext_test(2'h1, 16'h0020, 3, 16'hc3c3);
        ext_test(2'h2, 16'h0030, 0, 16'h3c3c);
        // Slow device: ready still low when the count runs out
        stall <= 8'h09;
        cpu_acc(2'h1, 1'b0, 16'h0020, 16'h0, rd, lo, pins, hit);
        check("ready stretch", lo, 12);
        check("stretched data", rd, 16'hc3c3);
        stall <= 8'h00;
        cpu_acc(2'h2, 1'b1, 16'hffff, 16'h0200, rd, lo, pins, hit);
        check("cfg via io", lo, 0);
        wb_xfer(1'b0, 8'h00, 32'h0, r);
        check("cfg io value", r, 32'h0200);
        cpu_acc(2'h2, 1'b0, 16'hffff, 16'h0, rd, lo, pins, hit);
        check("cfg io read", rd, 16'h0200);
        check("cfg io pins", lo, 0);
        cpu_acc(2'h3, 1'b0, 16'h0010, 16'h0, rd, lo, pins, hit);
        check("no space clocks", lo, 0);
        check("no space hit", hit, 0);
        ext_test(2'h2, 16'h0030, 1, 16'h1234);
        boot_memory_mode_select_i <= 1'b0;
        cpu_acc(2'h0, 1'b0, 16'h0010, 16'h0, rd, lo, pins, hit);
        check("rom clocks", lo, 0);
        check("rom hit", hit, 1);
        check("rom enable", onchip_rom_enable_o, 1);
        cpu_acc(2'h0, 1'b0, 16'h8010, 16'h0, rd, lo, pins, hit);
        check("upper off-chip", rd, 16'h5a52);
        check("upper clocks", lo, DIV);
        end_of_test();
    end
    initial begin
        #50000;
        miscompares++;
        end_of_test();
    end
endmodule
bind xbw_top xbw_monitor u_xbw_monitor (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .cpu_done_o,
    .rom_hit_o, .ext_addr_o, .ext_data_oe_o, .cpu_cycle_clock_out_o, .read_n_o, .write_enable_n_o,
    .external_access_strobe_n_o, .program_select_n_o,
    .data_space_select_n_o, .io_space_select_n_o, .read_not_write_o, .ready_i, .boot_memory_mode_select_i,
    .onchip_rom_enable_o);
